// ### rtl/fsrb_pkg.sv
package fsrb_pkg;
    // ========================================
    // register offsets
    localparam logic [11:0] OFS_FILE_NAME_INDEX   = 12'h000;
    localparam logic [11:0] OFS_FILE_LENGTH       = 12'h004;
    localparam logic [11:0] OFS_FORMAT_FILE_SIZE  = 12'h008;
    localparam logic [11:0] OFS_FILE_TIMESTAMP    = 12'h00c;
    localparam logic [11:0] OFS_FS_COMMAND        = 12'h010;
    localparam logic [11:0] OFS_FS_STATUS         = 12'h100;
    localparam logic [11:0] OFS_TOTAL_FILE_CAP    = 12'h104;
    localparam logic [11:0] OFS_ERROR_TYPE        = 12'h108;
    localparam logic [11:0] OFS_TEST_VECTOR_LOW   = 12'h10c;
    localparam logic [11:0] OFS_TEST_VECTOR_HIGH  = 12'h110;
    localparam logic [11:0] OFS_DIRECTORY_CAP     = 12'h114;
    localparam logic [11:0] OFS_DRIVE_FILE_SIZE   = 12'h118;
    localparam logic [11:0] OFS_DRIVE_FILE_COUNT  = 12'h11c;
    localparam logic [11:0] OFS_DRIVE_CAP_LOW     = 12'h120;
    localparam logic [11:0] OFS_DRIVE_CAP_HIGH    = 12'h124;
    localparam logic [11:0] OFS_TRANSFER_LOW      = 12'h128;
    localparam logic [11:0] OFS_TRANSFER_HIGH     = 12'h12c;
    localparam logic [11:0] OFS_CORE_VERSION      = 12'h800;
    // ========================================
    // area decode on address bits [11:8]
    localparam logic [3:0]  AREA_CONTROL          = 4'h0;
    localparam logic [3:0]  AREA_STATUS           = 4'h1;
    // ========================================
    // reset values and read latency
    localparam logic [26:0] RST_27                = 27'h0;
    localparam logic [2:0]  RST_3                 = 3'h0;
    localparam logic [1:0]  RST_2                 = 2'h0;
    localparam logic [31:0] RST_32                = 32'h0;
    localparam int          READ_LATENCY          = 2;
    // ========================================
    // timestamp field layout
    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [4:0] seconds;
    } fsrb_stamp_t;
    // status from the core
    typedef struct packed {
        logic        busy;
        logic        error;
        logic [26:0] total_capacity_files;
        logic [31:0] error_kind_vector;
        logic [63:0] debug_vector;
        logic [19:0] directory_room;
        logic [2:0]  drive_size_code;
        logic [26:0] drive_file_total;
        logic [47:0] sector_capacity;
        logic [56:0] transfer_bytes;
        logic [31:0] core_version_word;
    } fsrb_core_status_t;
endpackage : fsrb_pkg

// ### rtl/fsrb_register_bank.sv
// Behaviour
// [R1] control area 0x000-0x0ff is write only
// [R2] status area 0x100-0x1ff is read only
// [R3] offset 0x000 drives 27-bit file name index
// [R4] offset 0x004 drives 27-bit file length
// [R5] offset 0x008 holds format size code
// [R6] offset 0x00c splits into timestamp fields
// [R7] offset 0x010 latches command, pulses request
// [R8] 0x100 reads busy bit0, error bit1
// [R9] 0x104 reads 27-bit total file capacity
// [R10] 0x108 reads 32-bit error kind vector
// [R11] debug vector low 0x10c, high 0x110
// [R12] 0x114 reads 20-bit directory room
// [R13] 0x118 reads drive size code
// [R14] 0x11c reads 27-bit drive file count
// [R15] sector capacity low 0x120, high 0x124
// [R16] transfer count low 0x128, high 0x12c
// [R17] 0x800 reads core version word
// [R18] read valid two cycles after request
// [R19] area chosen by upper address bits
// [R20] unassigned bits and unmapped offsets read zero
// [R21] writes to status area are ignored
`timescale 1ns/1ns
`default_nettype none
module fsrb_register_bank (
    input  wire logic                        CLK,                  // 20 MHz clock
    input  wire logic                        RST_N,                // async reset, active low
    input  wire logic [11:0]                 REG_BUS_ADDR,         // byte address
    input  wire logic                        REG_WRITE_REQUEST,    // write strobe
    input  wire logic [31:0]                 REG_WRITE_DATA,       // write data
    input  wire logic                        REG_READ_REQUEST,     // read strobe
    output logic                             REG_READ_VALID,       // read data valid
    output logic [31:0]                      REG_READ_DATA,        // read data
    output logic [26:0]                      FILE_NAME_IN,         // to core
    output logic [26:0]                      FILE_LENGTH_IN,       // to core
    output logic [2:0]                       FORMAT_SIZE_CODE,     // to core
    output fsrb_pkg::fsrb_stamp_t            STAMP,                // timestamp fields to core
    output logic [1:0]                       COMMAND_CODE,         // to core
    output logic                             COMMAND_REQUEST,      // one-cycle pulse to core
    input  wire fsrb_pkg::fsrb_core_status_t CORE_STATUS           // from core
);
    // ========================================
    // decode
    logic        ctrl_wr;
    logic        is_status;
    logic [31:0] next_rd_data;
    logic [31:0] rd_data_s1;
    logic        rd_valid_s1;

    // write only in control area
    assign ctrl_wr   = REG_WRITE_REQUEST && (REG_BUS_ADDR[11:8] == fsrb_pkg::AREA_CONTROL); // [R19] [R1] [R21]
    assign is_status = (REG_BUS_ADDR[11:8] == fsrb_pkg::AREA_STATUS); // [R19] [R2]

    // ========================================
    // control registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FILE_NAME_IN     <= fsrb_pkg::RST_27;
            FILE_LENGTH_IN   <= fsrb_pkg::RST_27;
            FORMAT_SIZE_CODE <= fsrb_pkg::RST_3;
            STAMP            <= fsrb_pkg::RST_32;
            COMMAND_CODE     <= fsrb_pkg::RST_2;
        end else if (ctrl_wr) begin
            case (REG_BUS_ADDR)
                fsrb_pkg::OFS_FILE_NAME_INDEX:  FILE_NAME_IN     <= REG_WRITE_DATA[26:0]; // [R3]
                fsrb_pkg::OFS_FILE_LENGTH:      FILE_LENGTH_IN   <= REG_WRITE_DATA[26:0]; // [R4]
                fsrb_pkg::OFS_FORMAT_FILE_SIZE: FORMAT_SIZE_CODE <= REG_WRITE_DATA[2:0];  // [R5]
                fsrb_pkg::OFS_FILE_TIMESTAMP:   STAMP            <= REG_WRITE_DATA;       // [R6]
                fsrb_pkg::OFS_FS_COMMAND:       COMMAND_CODE     <= REG_WRITE_DATA[1:0];  // [R7]
                default: ;
            endcase
        end
    end

    // command request pulse, one cycle per write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            COMMAND_REQUEST <= 1'b0;
        end else begin
            COMMAND_REQUEST <= ctrl_wr && (REG_BUS_ADDR == fsrb_pkg::OFS_FS_COMMAND); // [R7]
        end
    end

    // ========================================
    // read mux
    always_comb begin
        next_rd_data = 32'h0; // [R20]
        if (is_status) begin
            case (REG_BUS_ADDR)
                fsrb_pkg::OFS_FS_STATUS:        next_rd_data = {30'h0, CORE_STATUS.error, CORE_STATUS.busy}; // [R8]
                fsrb_pkg::OFS_TOTAL_FILE_CAP:   next_rd_data = {5'h0, CORE_STATUS.total_capacity_files};   // [R9]
                fsrb_pkg::OFS_ERROR_TYPE:       next_rd_data = CORE_STATUS.error_kind_vector;              // [R10]
                fsrb_pkg::OFS_TEST_VECTOR_LOW:  next_rd_data = CORE_STATUS.debug_vector[31:0];             // [R11]
                fsrb_pkg::OFS_TEST_VECTOR_HIGH: next_rd_data = CORE_STATUS.debug_vector[63:32];            // [R11]
                fsrb_pkg::OFS_DIRECTORY_CAP:    next_rd_data = {12'h0, CORE_STATUS.directory_room};        // [R12]
                fsrb_pkg::OFS_DRIVE_FILE_SIZE:  next_rd_data = {29'h0, CORE_STATUS.drive_size_code};       // [R13]
                fsrb_pkg::OFS_DRIVE_FILE_COUNT: next_rd_data = {5'h0, CORE_STATUS.drive_file_total};       // [R14]
                fsrb_pkg::OFS_DRIVE_CAP_LOW:    next_rd_data = CORE_STATUS.sector_capacity[31:0];          // [R15]
                fsrb_pkg::OFS_DRIVE_CAP_HIGH:   next_rd_data = {16'h0, CORE_STATUS.sector_capacity[47:32]}; // [R15]
                fsrb_pkg::OFS_TRANSFER_LOW:     next_rd_data = CORE_STATUS.transfer_bytes[31:0];           // [R16]
                fsrb_pkg::OFS_TRANSFER_HIGH:    next_rd_data = {7'h0, CORE_STATUS.transfer_bytes[56:32]};  // [R16]
                default:                        next_rd_data = 32'h0; // [R20]
            endcase
        end else if (REG_BUS_ADDR == fsrb_pkg::OFS_CORE_VERSION) begin
            next_rd_data = CORE_STATUS.core_version_word; // [R17]
        end
    end

    // ========================================
    // two-stage read pipeline
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_valid_s1    <= 1'b0;
            REG_READ_VALID <= 1'b0;
            rd_data_s1     <= fsrb_pkg::RST_32;
            REG_READ_DATA  <= fsrb_pkg::RST_32;
        end else begin
            rd_valid_s1    <= REG_READ_REQUEST; // [R18]
            REG_READ_VALID <= rd_valid_s1;      // [R18]
            rd_data_s1     <= next_rd_data;
            REG_READ_DATA  <= rd_data_s1;
        end
    end
endmodule : fsrb_register_bank
`default_nettype wire

// ### tb/fsrb_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fsrb_monitor (
    input wire logic                        CLK, RST_N, REG_WRITE_REQUEST, REG_READ_REQUEST, // clock, strobes
    input wire logic                        REG_READ_VALID, COMMAND_REQUEST,                 // bank strobes
    input wire logic [11:0]                 REG_BUS_ADDR,                                    // address
    input wire logic [31:0]                 REG_WRITE_DATA, REG_READ_DATA,                   // data
    input wire logic [26:0]                 FILE_NAME_IN, FILE_LENGTH_IN,                    // core levels
    input wire logic [2:0]                  FORMAT_SIZE_CODE,                                // size code
    input wire logic [1:0]                  COMMAND_CODE,                                    // command
    input wire fsrb_pkg::fsrb_stamp_t       STAMP,                                           // timestamp
    input wire fsrb_pkg::fsrb_core_status_t CORE_STATUS                                      // core status
);
    // ========================================
    // bus timing and mapping
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence wr_at(logic [11:0] a); REG_WRITE_REQUEST && REG_BUS_ADDR == a; endsequence
    read_latency_a: assert property (REG_READ_REQUEST |-> ##2 REG_READ_VALID) else $error("valid late");
    valid_cause_a: assert property (REG_READ_VALID |-> $past(REG_READ_REQUEST, 2)) else $error("stray valid");
    cmd_pulse_a: assert property (wr_at(12'h010) |=> COMMAND_REQUEST && COMMAND_CODE == 2'($past(REG_WRITE_DATA)))
        else $error("no command pulse");
    cmd_cause_a: assert property (COMMAND_REQUEST |-> $past(REG_WRITE_REQUEST) && $past(REG_BUS_ADDR) == 12'h010)
        else $error("stray pulse");
    stamp_a: assert property (wr_at(12'h00c) |=> STAMP == $past(REG_WRITE_DATA)) else $error("stamp");
    status_wr_a: assert property (REG_WRITE_REQUEST && REG_BUS_ADDR[11:8] != 4'h0 |=> !COMMAND_REQUEST
        && $stable(FILE_NAME_IN) && $stable(STAMP)) else $error("status write took effect");
    busy_read_a: assert property (REG_READ_REQUEST && REG_BUS_ADDR == 12'h100 |-> ##2
        REG_READ_DATA == {30'h0, $past(CORE_STATUS.error, 2), $past(CORE_STATUS.busy, 2)}) else $error("status");
    ctrl_read_a: assert property (REG_READ_REQUEST && REG_BUS_ADDR[11:8] == 4'h0 |-> ##2 REG_READ_DATA == 32'h0)
        else $error("control read");
endmodule : fsrb_monitor
bind fsrb_register_bank fsrb_monitor i_fsrb_monitor (.*);
`default_nettype wire

// ### tb/fsrb_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsrb_core_model (
    input  wire logic                      CLK,    // clock
    input  wire logic [31:0]               seed,   // status pattern
    output var fsrb_pkg::fsrb_core_status_t status // status to bank
);
    // ========================================
    // status fields filled from the pattern
    always_ff @(posedge CLK) begin
        status <= 312'({10{seed}});
    end
endmodule : fsrb_core_model
`default_nettype wire

// ### tb/fsrb_register_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fsrb_register_bank_tb;
    logic clk = 0, rst_n = 0, we = 0, re = 0, vld, cq;
    logic [11:0] addr = 12'h0;
    logic [31:0] wd = 32'h0, seed = 32'h0, rv, d, q[$];
    logic [26:0] fn, fl;
    logic [2:0] fs;
    logic [1:0] cc;
    fsrb_pkg::fsrb_stamp_t st;
    fsrb_pkg::fsrb_core_status_t cs;
    int mismatches = 0, checks = 0;
    fsrb_register_bank i_fsrb_register_bank (.CLK(clk), .RST_N(rst_n), .REG_BUS_ADDR(addr), .REG_WRITE_REQUEST(we),
        .REG_WRITE_DATA(wd), .REG_READ_REQUEST(re), .REG_READ_VALID(vld), .REG_READ_DATA(rv), .FILE_NAME_IN(fn),
        .FILE_LENGTH_IN(fl), .FORMAT_SIZE_CODE(fs), .STAMP(st), .COMMAND_CODE(cc), .COMMAND_REQUEST(cq), .CORE_STATUS(cs));
    fsrb_core_model i_fsrb_core_model (.CLK(clk), .seed(seed), .status(cs));
    initial forever #25 clk = ~clk;
    // ========================================
    // compare, bus tasks, expected read values
    task cmp(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    function automatic logic [31:0] expv(input logic [11:0] a);
        case (a)
            12'h100: return {30'h0, cs.error, cs.busy};
            12'h104: return {5'h0, cs.total_capacity_files};
            12'h108: return cs.error_kind_vector;
            12'h10c: return cs.debug_vector[31:0];
            12'h110: return cs.debug_vector[63:32];
            12'h114: return {12'h0, cs.directory_room};
            12'h118: return {29'h0, cs.drive_size_code};
            12'h11c: return {5'h0, cs.drive_file_total};
            12'h120: return cs.sector_capacity[31:0];
            12'h124: return {16'h0, cs.sector_capacity[47:32]};
            12'h128: return cs.transfer_bytes[31:0];
            12'h12c: return {7'h0, cs.transfer_bytes[56:32]};
            12'h800: return cs.core_version_word;
            default: return 32'h0;
        endcase
    endfunction : expv
    task bus(input logic w, r, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        #5;
        {we, re, addr, wd} = {w, r, a, v};
        if (r) q.push_back(expv(a));
    endtask : bus
    // read results checked against the oldest note
    always @(posedge clk) if (vld === 1'b1) cmp("read", q.pop_front(), rv);
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        mismatches++;
        report_and_stop;
    end
    // ========================================
    // main sequence: writes back to back, then every read offset
    initial begin
        void'($urandom(32'h97d099ac));
        repeat (20) @(posedge clk);
        #5 rst_n = 1;
        for (int p = 0; p < 2; p++) begin
            seed = $urandom;
            d = $urandom;
            bus(1, 0, 12'h000, d);
            bus(1, 0, 12'h004, ~d);
            bus(1, 0, 12'h008, d);
            bus(1, 0, 12'h00c, d);
            bus(1, 0, 12'h010, d);
            bus(1, 0, 12'h010, ~d);
            bus(1, 0, 12'h104, d);
            bus(0, 0, 12'h0, 32'h0);
            cmp("name", {5'h0, d[26:0]}, {5'h0, fn});
            cmp("length", {5'h0, ~d[26:0]}, {5'h0, fl});
            cmp("size", {29'h0, d[2:0]}, {29'h0, fs});
            cmp("stamp", d, st);
            cmp("command", {30'h0, ~d[1:0]}, {30'h0, cc});
            for (int i = 0; i < 12; i++) bus(0, 1, 12'h100 + 12'(4 * i), 32'h0);
            bus(0, 1, 12'h800, 32'h0);
            bus(0, 1, 12'h010, 32'h0);
            bus(0, 1, 12'h130, 32'h0);
            repeat (4) bus(0, 0, 12'h0, 32'h0);
            $display("pass %0d done", p);
        end
        report_and_stop;
    end
endmodule : fsrb_register_bank_tb
`default_nettype wire
